// [include/btxcc_pkg.sv]
// shared constants for the bit-stuffing transmitter character control
package btxcc_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] SILO_OFFSET   = 8'h08;
    localparam logic [7:0] COUNT_OFFSET  = 8'h0C;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_SEND_BIT     = 0;  // send request, level
    localparam int CTRL_START_BIT    = 1;  // write one: begin a new message
    localparam int CTRL_OUTCLR_BIT   = 2;  // write one: out-side clear
    localparam int CTRL_BUSCLR_BIT   = 3;  // write one: bus out clear

    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int STAT_ACTIVE_BIT   = 0;
    localparam int STAT_DONE_BIT     = 1;
    localparam int STAT_LATE_BIT     = 2;
    localparam int STAT_GATE_BIT     = 3;
    localparam int STAT_AVAIL_BIT    = 4;
    localparam int STAT_FIVE_BIT     = 5;
    localparam int STAT_SIX_BIT      = 6;
    localparam int STAT_RTS_BIT      = 7;
    localparam int STAT_SEND_BIT     = 8;

    // ------------------------------------------------------------
    // count register fields
    // ------------------------------------------------------------
    localparam int COUNT_CHAR_LSB    = 0;  // 4-bit character counter
    localparam int COUNT_ONES_LSB    = 8;  // 8-bit ones shift register

    // ------------------------------------------------------------
    // character counter and ones counter
    // ------------------------------------------------------------
    localparam logic [3:0] CHAR_PRESET_DATA = 4'h8;  // 8-bit characters
    localparam logic [3:0] CHAR_PRESET_CRC  = 4'h0;  // 16-bit check character
    localparam logic [3:0] CHAR_COUNT_MAX   = 4'hF;
    localparam int         ONES_FIVE_BIT    = 4;
    localparam int         ONES_SIX_BIT     = 5;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic       DONE_RESET = 1'b1;     // initialization sets done
    localparam logic       MARK_LEVEL = 1'b1;     // idle line level

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS   = 10;
    localparam int BIT_PULSE_NS      = 200;
    localparam int DONE_PULSE_NS     = 40;
    // least times, rounded up to whole cycles
    localparam int BIT_PULSE_CYCLES  = (BIT_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int DONE_PULSE_CYCLES = (DONE_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

endpackage : btxcc_pkg

// [design/btxcc_tx_char_control.sv]
// transmitter character control: ones counter, character counter, status and serializer
//
// Behaviour
// R1: ones counter flags five and six ones
// R2: five/six pick flag bits, else stuff
// R3: zero after five ones, clears counter
// R4: frames open and close with flags
// R5: count character bits, skip stuffed zeros
// R6: preset 0 for check, 8 else
// R7: counter disabled during stuffed zero
// R8: count per bit, reload, preset when idle
// R9: active flag from control, bus clear
// R10: done cleared on silo-available rising edge
// R11: out-side clear sets done
// R12: silo accept during pulse sets done
// R13: send clear ends message, sets done
// R14: data late if done at character end; the code never sets it on a flag character
// R15: after late, drop gate and RTS
// R16: 8-bit serializer, least significant first
// R17: shift only on pulse with enable
// R18: load silo byte on pulse request
// R19: ones shift in, zero clears
// R20: gate low forces line to mark
// R21: software refills silo before character end
`timescale 1ns/10ps

module btxcc_tx_char_control
    import btxcc_pkg::*;
#(
    parameter int PULSE_CYCLES = BIT_PULSE_CYCLES,
    parameter int DONE_CYCLES  = DONE_PULSE_CYCLES
)
(
    // system
    input  wire logic        clock,
    input  wire logic        resetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // modem link
    input  wire logic        txBitClock,
    output logic             serialLine,
    output logic             requestToSend,
    // control rom outputs (same clock)
    input  wire logic        txActiveRom,
    input  wire logic        siloAccept,
    input  wire logic        flagCharSending,
    input  wire logic        crcCharNext,
    input  wire logic        charCountEnable,
    input  wire logic        serializerShiftEn,
    input  wire logic        serializerLoadReq,
    // indications back to the control rom
    output logic             onesRunFive,
    output logic             onesRunSix,
    output logic             charEndPulse,
    output logic             bitClockPulse,
    output logic             serialBitOut,
    output logic             txActiveFlag
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    initial
    begin
        if (PULSE_CYCLES < 1 || PULSE_CYCLES > 255)
            $error("PULSE_CYCLES out of range");
        if (DONE_CYCLES < 1 || DONE_CYCLES > 15)
            $error("DONE_CYCLES out of range");
    end

    localparam logic [7:0] PULSE_LOAD = 8'(PULSE_CYCLES);
    localparam logic [3:0] DONE_LOAD  = 4'(DONE_CYCLES);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        clkSync1;
        logic        clkSync2;
        logic        clkPrev;
        logic [7:0]  pulseCnt;
        logic        bitClockPulse;
        logic [3:0]  doneCnt;
        logic [7:0]  serializer;
        logic [7:0]  onesShift;
        logic [3:0]  charCount;
        logic        charEndPulse;
        logic        stuffBit;
        logic        txActiveNext;
        logic        txActiveFlag;
        logic        done;
        logic        dataLate;
        logic        sendGate;
        logic        requestToSend;
        logic        nextBit;
        logic        lineBit;
        logic [7:0]  siloByte;
        logic        siloAvail;
        logic        sendReq;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } btxcc_state_t;

    btxcc_state_t state_reg;
    btxcc_state_t state_next;

    // ------------------------------------------------------------
    // combinational helpers
    // ------------------------------------------------------------
    logic clkRise;
    logic clkFall;
    logic stuffZero;
    logic apbSetup;
    logic apbWrite;
    logic outClear;
    logic busClear;
    logic startMsg;
    logic siloWrite;
    logic charEnd;
    logic presetCount;
    logic [31:0] readData;
    logic        readErr;

    // modem clock edges; only the second stage reads the first
    assign clkRise = state_reg.clkSync2 & ~state_reg.clkPrev;
    assign clkFall = ~state_reg.clkSync2 & state_reg.clkPrev;

    // R2 flag bits go as loaded, never stuffed
    assign stuffZero = state_reg.onesShift[ONES_FIVE_BIT] & ~flagCharSending
                     & state_reg.txActiveFlag;

    // bus decode; writes land when the access completes
    assign apbSetup  = psel & ~penable;
    assign apbWrite  = psel & penable & state_reg.pready & pwrite;
    assign outClear  = apbWrite && paddr == CTRL_OFFSET && pwdata[CTRL_OUTCLR_BIT];
    assign busClear  = apbWrite && paddr == CTRL_OFFSET && pwdata[CTRL_BUSCLR_BIT];
    assign startMsg  = apbWrite && paddr == CTRL_OFFSET && pwdata[CTRL_START_BIT];
    assign siloWrite = apbWrite && paddr == SILO_OFFSET;

    // R5 end of character when counting past the maximum
    assign charEnd = clkFall & state_reg.txActiveFlag
                   & (state_reg.charCount == CHAR_COUNT_MAX)
                   & charCountEnable & ~state_reg.stuffBit;
    // R8 preset on character end or while the transmitter is idle
    assign presetCount = charEnd | ~state_reg.txActiveFlag;

    // read mux, prepared in the setup cycle
    always_comb
    begin
        readData = 32'h0000_0000;
        readErr  = 1'b0;
        case (paddr)
            CTRL_OFFSET:
            begin
                readData[CTRL_SEND_BIT] = state_reg.sendReq;
            end
            STATUS_OFFSET:
            begin
                readData[STAT_ACTIVE_BIT] = state_reg.txActiveFlag;
                readData[STAT_DONE_BIT]   = state_reg.done;
                readData[STAT_LATE_BIT]   = state_reg.dataLate;
                readData[STAT_GATE_BIT]   = state_reg.sendGate;
                readData[STAT_AVAIL_BIT]  = state_reg.siloAvail;
                readData[STAT_FIVE_BIT]   = state_reg.onesShift[ONES_FIVE_BIT];
                readData[STAT_SIX_BIT]    = state_reg.onesShift[ONES_SIX_BIT];
                readData[STAT_RTS_BIT]    = state_reg.requestToSend;
                readData[STAT_SEND_BIT]   = state_reg.sendReq;
            end
            SILO_OFFSET:
            begin
                readData[7:0] = state_reg.siloByte;
            end
            COUNT_OFFSET:
            begin
                readData[COUNT_CHAR_LSB +: 4] = state_reg.charCount;
                readData[COUNT_ONES_LSB +: 8] = state_reg.onesShift;
            end
            default:
            begin
                readErr = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;

        // two-flop synchroniser and edge memory
        state_next.clkSync1 = txBitClock;
        state_next.clkSync2 = state_reg.clkSync1;
        state_next.clkPrev  = state_reg.clkSync2;

        // one-cycle strobes drop by default
        state_next.charEndPulse = 1'b0;

        // apb: one wait state, pready high two cycles after setup
        state_next.pready = psel & penable & ~state_reg.pready;
        if (apbSetup)
        begin
            state_next.prdata  = pwrite ? 32'h0000_0000 : readData;
            state_next.pslverr = readErr;
        end
        if (apbWrite && paddr == CTRL_OFFSET)
        begin
            state_next.sendReq = pwdata[CTRL_SEND_BIT];
        end

        // per-bit clock pulse, started by the rising modem clock edge
        if (clkRise)
        begin
            state_next.pulseCnt      = PULSE_LOAD;
            state_next.bitClockPulse = 1'b1;
            // R20 line follows the held next bit; gate low holds mark
            state_next.lineBit = state_reg.sendGate ? state_reg.nextBit : MARK_LEVEL;
            // R18 parallel load wins, shifting suppressed
            if (serializerLoadReq)
            begin
                state_next.serializer = state_reg.siloByte;
                state_next.siloAvail  = 1'b0;
            end
            // R17 shift on pulse with enable, not while stuffing
            else if (serializerShiftEn && !stuffZero)
            begin
                // R16 least significant bit leaves first
                state_next.serializer = {1'b0, state_reg.serializer[7:1]};
            end
        end
        else if (state_reg.pulseCnt != 8'h00)
        begin
            state_next.pulseCnt = state_reg.pulseCnt - 8'h01;
            if (state_reg.pulseCnt == 8'h01)
            begin
                state_next.bitClockPulse = 1'b0;
                // capture the next bit at pulse end
                if (!state_reg.sendGate || !state_reg.txActiveFlag)
                begin
                    // R20 idle or gated-off line stays at mark
                    state_next.nextBit  = MARK_LEVEL;
                    state_next.stuffBit = 1'b0;
                end
                else if (stuffZero)
                begin
                    // R3 stuffed zero after five contiguous ones
                    state_next.nextBit  = 1'b0;
                    state_next.stuffBit = 1'b1;
                end
                else
                begin
                    state_next.nextBit  = state_reg.serializer[0];
                    state_next.stuffBit = 1'b0;
                end
            end
        end

        // falling modem clock edge: counters and active flag
        if (clkFall)
        begin
            // R19 ones shift in, any zero clears the run
            if (state_reg.nextBit)
            begin
                state_next.onesShift = {state_reg.onesShift[6:0], 1'b1};
            end
            else
            begin
                // R3 the stuffed zero clears the ones counter
                state_next.onesShift = 8'h00;
            end

            // R9 active flag follows the sync buffer each bit time
            state_next.txActiveFlag = state_reg.txActiveNext;

            // R8 reload on end or idle, otherwise advance
            if (presetCount)
            begin
                // R6 preset 0 for a check character, 8 otherwise
                state_next.charCount = crcCharNext ? CHAR_PRESET_CRC : CHAR_PRESET_DATA;
                // R13 sync buffer reloads; send clear ends the message
                state_next.txActiveNext = txActiveRom & state_reg.sendReq;
            end
            // R7 counter held during a stuffed zero
            else if (charCountEnable && !state_reg.stuffBit)
            begin
                state_next.charCount = state_reg.charCount + 4'h1;
            end
        end

        // character end events
        if (charEnd)
        begin
            state_next.charEndPulse = 1'b1;
            // R15 pending late error drops gate and RTS
            if (state_reg.dataLate)
            begin
                state_next.sendGate      = 1'b0;
                state_next.requestToSend = 1'b0;
            end
            // R14 late when done still set, never on a flag character
            if (state_reg.done && !flagCharSending)
            begin
                state_next.dataLate = 1'b1;
            end
        end

        // R13 active falling from the sync buffer starts the short done pulse
        if (state_reg.txActiveFlag && !state_next.txActiveFlag)
        begin
            state_next.doneCnt = DONE_LOAD;
        end
        else if (state_reg.doneCnt != 4'h0)
        begin
            state_next.doneCnt = state_reg.doneCnt - 4'h1;
        end

        // start: gate and request on; a late error raised now still wins
        if (startMsg)
        begin
            state_next.sendGate      = 1'b1;
            state_next.requestToSend = 1'b1;
            state_next.dataLate      = charEnd & state_reg.done & ~flagCharSending;
        end

        // silo write makes data available to the transmitter
        if (siloWrite)
        begin
            state_next.siloByte  = pwdata[7:0];
            state_next.siloAvail = 1'b1;
        end

        // R10 done clears only on the silo-available rising edge
        if (state_next.siloAvail && !state_reg.siloAvail)
        begin
            state_next.done = 1'b0;
        end
        // set sources win over the clear
        // R12 accept during the bit pulse sets done
        if (siloAccept && state_reg.bitClockPulse)
        begin
            state_next.done = 1'b1;
        end
        // R13 done set by the end-of-message pulse
        if (state_reg.doneCnt != 4'h0)
        begin
            state_next.done = 1'b1;
        end
        // R11 out-side clear forces done
        if (outClear)
        begin
            state_next.done          = 1'b1;
            state_next.sendGate      = 1'b0;
            state_next.requestToSend = 1'b0;
            state_next.siloAvail     = 1'b0;
            state_next.nextBit       = MARK_LEVEL;
        end

        // R9 bus clear drops active flag and buffer
        if (busClear)
        begin
            state_next.txActiveFlag = 1'b0;
            state_next.txActiveNext = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg               <= '0;
            state_reg.done          <= DONE_RESET;
            state_reg.nextBit       <= MARK_LEVEL;
            state_reg.lineBit       <= MARK_LEVEL;
            state_reg.charCount     <= CHAR_PRESET_DATA;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from the state register
    // ------------------------------------------------------------
    assign prdata        = state_reg.prdata;
    assign pready        = state_reg.pready;
    assign pslverr       = state_reg.pslverr;
    // R4 flags come from the loaded characters
    assign serialLine    = state_reg.lineBit;
    assign requestToSend = state_reg.requestToSend;
    // R1 five stays high together with six
    assign onesRunFive   = state_reg.onesShift[ONES_FIVE_BIT];
    assign onesRunSix    = state_reg.onesShift[ONES_SIX_BIT];
    assign charEndPulse  = state_reg.charEndPulse;
    assign bitClockPulse = state_reg.bitClockPulse;
    assign serialBitOut  = state_reg.serializer[0];
    assign txActiveFlag  = state_reg.txActiveFlag;

endmodule : btxcc_tx_char_control

// [dv/btxcc_tx_char_control_properties.sv]
// port assertions for the transmitter character control
`timescale 1ns/10ps

module btxcc_tx_char_control_properties
    import btxcc_pkg::*;
#(
    parameter int PULSE_CYCLES = BIT_PULSE_CYCLES
)
(
    // system
    input wire logic        clock,
    input wire logic        resetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // line and indications
    input wire logic        serialLine,
    input wire logic        requestToSend,
    input wire logic        onesRunFive,
    input wire logic        onesRunSix,
    input wire logic        charEndPulse,
    input wire logic        bitClockPulse,
    input wire logic        serialBitOut,
    input wire logic        txActiveFlag
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    // length of the current bit pulse, cleared while low
    logic [7:0] pulseLen;
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            pulseLen <= 8'h00;
        else
            pulseLen <= bitClockPulse ? pulseLen + 8'h01 : 8'h00;
    end

    // completed write to the control word
    sequence ctrl_write_s;
        psel && penable && pready && pwrite && (paddr == CTRL_OFFSET);
    endsequence
    sequence apb_access_s;
        psel && $rose(penable);
    endsequence

    six_needs_five_a: assert property (onesRunSix |-> onesRunFive)
        else $error("six without five");
    six_after_five_a: assert property ($rose(onesRunSix) |-> $past(onesRunFive))
        else $error("six rose early");
    end_pulse_single_a: assert property (charEndPulse |=> !charEndPulse)
        else $error("end pulse too long");
    bit_pulse_len_a: assert property ($fell(bitClockPulse) |-> pulseLen == PULSE_CYCLES)
        else $error("bit pulse length");
    shift_on_pulse_a: assert property ($changed(serialBitOut) |-> bitClockPulse)
        else $error("shift off pulse");
    space_at_bit_a: assert property ($fell(serialLine) |-> $rose(bitClockPulse))
        else $error("space off bit time");
    active_bus_clear_a: assert property (ctrl_write_s ##0 pwdata[CTRL_BUSCLR_BIT] |=> !txActiveFlag)
        else $error("bus clear missed");
    rts_out_clear_a: assert property (ctrl_write_s ##0 pwdata[CTRL_OUTCLR_BIT] |=> !requestToSend)
        else $error("out clear missed");
    apb_one_wait_a: assert property (apb_access_s |=> pready) // APB
        else $error("apb wait wrong");
    apb_unmapped_a: assert property (psel && penable && pready && paddr > COUNT_OFFSET
        |-> pslverr && prdata == 32'h0) // APB
        else $error("unmapped accepted");
endmodule : btxcc_tx_char_control_properties

bind btxcc_tx_char_control btxcc_tx_char_control_properties #(.PULSE_CYCLES(PULSE_CYCLES)) u_props (
    .clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .serialLine, .requestToSend, .onesRunFive, .onesRunSix, .charEndPulse, .bitClockPulse,
    .serialBitOut, .txActiveFlag);

// [dv/btxcc_modem_model.sv]
// modem model: transmit bit clock, running while asked
`timescale 1ns/10ps

module btxcc_modem_model
#(
    parameter int HALF_NS = 40
)
(
    // request from the bench
    input  wire logic run,
    // clock toward the line unit
    output logic      txBitClock
);
    // odd offset keeps the phase unrelated to the system clock
    initial
    begin
        txBitClock = 1'b0;
        #3.3;
        forever
        begin
            #(HALF_NS);
            txBitClock = run ? ~txBitClock : 1'b0;
        end
    end
endmodule : btxcc_modem_model

// [dv/btxcc_tx_char_control_bench.sv]
// self-checking bench for the transmitter character control
`timescale 1ns/10ps

module btxcc_tx_char_control_bench
    import btxcc_pkg::*;
;
    logic        clock = 1'b0, resetn = 1'b0, linkRun = 1'b0, lastErr, seenZero = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, prevPulse = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic        pready, pslverr, txBitClock, serialLine, requestToSend, onesRunFive;
    logic        onesRunSix, charEndPulse, bitClockPulse, serialBitOut, txActiveFlag;
    logic        txActiveRom = 1'b0, siloAccept = 1'b0, flagCharSending = 1'b0;
    logic        crcCharNext = 1'b0, charCountEnable = 1'b0, serializerShiftEn = 1'b0;
    logic        serializerLoadReq = 1'b0;
    int          errors = 0, checks = 0, cycles = 0, gap = 0, lastGap = 0, run = 0, maxRun = 0;

    btxcc_tx_char_control #(.PULSE_CYCLES(2), .DONE_CYCLES(2)) u_btxcc_tx_char_control (
        .clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .txBitClock, .serialLine, .requestToSend, .txActiveRom, .siloAccept, .flagCharSending,
        .crcCharNext, .charCountEnable, .serializerShiftEn, .serializerLoadReq, .onesRunFive,
        .onesRunSix, .charEndPulse, .bitClockPulse, .serialBitOut, .txActiveFlag);
    btxcc_modem_model u_btxcc_modem_model (.run(linkRun), .txBitClock);

    // 100 MHz system clock
    always #5 clock = ~clock;

    // watchdog and line monitor
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        prevPulse <= bitClockPulse;
        if (bitClockPulse === 1'b1 && prevPulse === 1'b0)
        begin
            gap <= gap + 1;
            if (serialLine === 1'b0)
            begin
                seenZero <= 1'b1;
                run <= 0;
            end
            else if (seenZero)
            begin
                run <= run + 1;
                if (run + 1 > maxRun)
                    maxRun <= run + 1;
            end
        end
        if (charEndPulse === 1'b1)
        begin
            lastGap <= gap;
            gap <= 0;
        end
        if (cycles == 60000)
        begin
            errors++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // bus tasks and comparisons
    // ------------------------------------------------------------
    task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                            output logic [31:0] q);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
            @(posedge clock);
        while (pready !== 1'b1);
        q = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb_xfer(1'b1, a, d, rdata);
    endtask : wr

    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check_word

    task automatic check_bit(input string name, input logic exp, input logic got);
        check_word(name, {31'h0, exp}, {31'h0, got});
    endtask : check_bit

    task automatic expect_reg(input string name, input logic [7:0] a, input logic [31:0] mask,
                              input logic [31:0] exp);
        apb_xfer(1'b0, a, 32'h0, rdata);
        check_word(name, exp, rdata & mask);
    endtask : expect_reg

    // wait for n end pulses, plus one edge
    task automatic wait_ends(input int n);
        repeat (n)
        begin
            @(posedge clock);
            while (charEndPulse !== 1'b1)
                @(posedge clock);
        end
        @(posedge clock);
    endtask : wait_ends

    task automatic final_report;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        expect_reg("status reset", STATUS_OFFSET, 32'h1FF, 32'h002);
        expect_reg("count reset", COUNT_OFFSET, 32'hFFFF, 32'h008);
        apb_xfer(1'b0, 8'h10, 32'h0, rdata);
        check_bit("unmapped error", 1'b1, lastErr); // APB
        check_word("unmapped data", 32'h0, rdata); // APB
        // all-zero characters
        charCountEnable <= 1'b1;
        serializerShiftEn <= 1'b1;
        serializerLoadReq <= 1'b1;
        txActiveRom <= 1'b1;
        wr(SILO_OFFSET, 32'h00);
        expect_reg("silo avail", STATUS_OFFSET, 32'h012, 32'h010);
        wr(CTRL_OFFSET, 32'h3);
        linkRun = 1'b1;
        wait_ends(3);
        check_word("data gap", 32'd8, lastGap);
        crcCharNext <= 1'b1;
        wait_ends(3);
        check_word("check gap", 32'd16, lastGap);
        crcCharNext <= 1'b0;
        // all-ones characters
        @(negedge clock);
        seenZero = 1'b0;
        maxRun = 0;
        wr(SILO_OFFSET, 32'hFF);
        wait_ends(4);
        check_word("longest run", 32'd5, maxRun);
        siloAccept <= 1'b1;
        wait_ends(3);
        expect_reg("late status", STATUS_OFFSET, 32'h08E, 32'h006);
        check_bit("rts dropped", 1'b0, requestToSend);
        @(negedge clock);
        seenZero = 1'b0;
        repeat (64) @(posedge clock);
        check_bit("held mark", 1'b0, seenZero);
        // flag characters
        flagCharSending <= 1'b1;
        @(negedge clock);
        seenZero = 1'b1;
        maxRun = 0;
        wr(CTRL_OFFSET, 32'h3);
        wait_ends(3);
        expect_reg("flag status", STATUS_OFFSET, 32'h08C, 32'h088);
        check_bit("flag six ones", 1'b1, maxRun > 5);
        wait_ends(1);
        wr(CTRL_OFFSET, 32'h9);
        // end of message
        siloAccept <= 1'b0;
        flagCharSending <= 1'b0;
        wr(SILO_OFFSET, 32'h00);
        repeat (24) @(posedge clock);
        txActiveRom <= 1'b0;
        wr(CTRL_OFFSET, 32'h0);
        repeat (200) @(posedge clock);
        check_bit("active ended", 1'b0, txActiveFlag);
        check_bit("idle mark", 1'b1, serialLine);
        expect_reg("end status", STATUS_OFFSET, 32'h003, 32'h002);
        expect_reg("count idle", COUNT_OFFSET, 32'h00F, 32'h008);
        wr(SILO_OFFSET, 32'h00);
        wr(CTRL_OFFSET, 32'h4);
        expect_reg("out clear", STATUS_OFFSET, 32'h09A, 32'h002);
        final_report();
    end
endmodule : btxcc_tx_char_control_bench
